/* hdl/trs_pkg.sv */
// Constants and types of the trip-started reclose sequencer.
// Assumes a 10 MHz system clock and a 1 ms time base for all timers.
package trs_pkg;
  localparam int NREQ = 5;
  localparam int TW   = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] SHOT_OFS  = 8'h04;
  localparam logic [7:0] DEAD1_OFS = 8'h08;
  localparam logic [7:0] DEAD2_OFS = 8'h0c;
  localparam logic [7:0] RECL_OFS  = 8'h10;
  localparam logic [7:0] OVR_OFS   = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h18;

  // Control field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_LRST_BIT  = 1;
  localparam int CTRL_OVR_BIT   = 2;
  localparam int CTRL_OLOCK_BIT = 3;
  localparam int CTRL_SRST_BIT  = 4;

  // Values after reset; timer settings are in ms
  localparam logic [3:0]    CTRL_RST  = 4'hd;
  localparam logic [1:0]    SHOT_RST  = 2'h3;
  localparam logic [TW-1:0] DEAD1_RST = 16'h00c8;
  localparam logic [TW-1:0] DEAD2_RST = 16'hea60;
  localparam logic [TW-1:0] RECL_RST  = 16'h2710;
  localparam logic [TW-1:0] OVR_RST   = 16'h2710;

  // Time base
  localparam int CLK_NS       = 100;
  localparam int TICK_NS      = 1000000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;

  typedef enum logic [2:0] {
    ST_READY = 3'h0,
    ST_WOPEN = 3'h1,
    ST_DEAD  = 3'h3,
    ST_CLOSE = 3'h2,
    ST_RECL  = 3'h6,
    ST_OVR   = 3'h7,
    ST_FINAL = 3'h5,
    ST_LOCK  = 3'h4
  } trs_state_t;
endpackage

/* hdl/trs_sequencer.sv */
// Trip-started two-shot reclose sequencer with AHB-Lite register slave.
// Assumes request, breaker status and failure inputs come from logic on hclk.
//
// Contract
// - A protection trip drives one of the request inputs and starts the cycle.
// - Trip start uses no starting or discrimination delay.
// - Start raises running, the request's pending flag and shot-active together.
// - Breaker open plus released request starts the active shot's dead time.
// - Dead time expiry sends close request; breaker object gates the coil.
// - Close drops on breaker closed; shot reclaim timing starts then.
// - Request during shot reclaim advances to second shot.
// - Second shot dead time expiry closes like the first.
// - Request in reclaim with no shot left: final trip, flags clear, lockout.
// - Lockout ignores requests until manual reset and breaker closing.
// - Quiet shot reclaim expiry clears flags and starts overall reclaim.
// - Fault during overall reclaim goes final trip unless setting says otherwise.
// - Zero reclaim settings skip their timers.
// - Setting can omit the overall reclaim phase.
// - Overall reclaim expiry returns to ready.
// - Shots are enabled separately, each with its own dead time.
// - Five prioritised requests, lowest index wins; critical request halts all.
// - Open or close failure locks out unless a restart is written in the same cycle.
// - Lockout clears by reset input and breaker closed.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int TICK_CYC = trs_pkg::TICK_CYC_DEF
)
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic [trs_pkg::NREQ-1:0] request,
  input  wire logic                    critical_request,
  input  wire logic                    breaker_open,
  input  wire logic                    breaker_closed,
  input  wire logic                    open_fail,
  input  wire logic                    close_fail,
  input  wire logic                    lockout_reset,
  output logic                         close_request,
  output logic                         final_trip,
  output logic                         recloser_active,
  output logic                         first_shot_active,
  output logic                         second_shot_active,
  output logic [trs_pkg::NREQ-1:0]     request_pending,
  output logic                         sequence_reclaim_active,
  output logic                         sequence_lockout
);
  import trs_pkg::*;

  // Bus slave state
  logic            wp_q, wp_d;
  logic [7:0]      wa_q, wa_d;
  logic [31:0]     rd_q, rd_d;
  logic [3:0]      ctrl_q, ctrl_d;
  logic [1:0]      shot_q, shot_d;
  logic [TW-1:0]   d1_q, d1_d, d2_q, d2_d, rc_q, rc_d, ov_q, ov_d;
  logic            ap, ctrl_wr, lrst, srst;
  // Sequencer state
  trs_state_t      st_q, st_d;
  logic [TW-1:0]   tmr_q, tmr_d;
  logic [2:0]      idx_q, idx_d, pick;
  logic            shot2_q, shot2_d, arm_q, arm_d, hit, req_cur, ovr_any;
  logic            act_d, s1_d, s2_d, rcl_d, lock_d, close_d, trip_d;
  logic [NREQ-1:0] pend_d;
  logic [31:0]     tc_q, tc_d;
  logic            tick_q, tick_d;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_q;
  assign ap        = hsel && htrans[1] && hready;
  assign ctrl_wr   = wp_q && (wa_q == CTRL_OFS);
  assign lrst      = (ctrl_wr && hwdata[CTRL_LRST_BIT]) || lockout_reset;
  assign srst      = ctrl_wr && hwdata[CTRL_SRST_BIT];

  always_comb
  begin
    wp_d   = ap && hwrite;
    wa_d   = ap ? haddr[7:0] : wa_q;
    rd_d   = rd_q;
    ctrl_d = ctrl_q;
    shot_d = shot_q;
    d1_d   = d1_q;
    d2_d   = d2_q;
    rc_d   = rc_q;
    ov_d   = ov_q;
    if (ap && !hwrite)
    begin
      case (haddr[7:0])
        CTRL_OFS:  rd_d = {28'h0, ctrl_q[3:2], 1'b0, ctrl_q[0]};
        SHOT_OFS:  rd_d = {30'h0, shot_q};
        DEAD1_OFS: rd_d = {16'h0, d1_q};
        DEAD2_OFS: rd_d = {16'h0, d2_q};
        RECL_OFS:  rd_d = {16'h0, rc_q};
        OVR_OFS:   rd_d = {16'h0, ov_q};
        STAT_OFS:  rd_d = {19'h0, st_q, sequence_lockout, sequence_reclaim_active,
                           request_pending, second_shot_active, first_shot_active,
                           recloser_active};
        default:   rd_d = 32'h0;
      endcase
    end
    if (wp_q)
    begin
      case (wa_q)
        CTRL_OFS:  ctrl_d = {hwdata[3:2], 1'b0, hwdata[0]};
        SHOT_OFS:  shot_d = hwdata[1:0];
        DEAD1_OFS: d1_d = hwdata[TW-1:0];
        DEAD2_OFS: d2_d = hwdata[TW-1:0];
        RECL_OFS:  rc_d = hwdata[TW-1:0];
        OVR_OFS:   ov_d = hwdata[TW-1:0];
        default:   ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp_q   <= 1'b0;
      wa_q   <= 8'h00;
      rd_q   <= 32'h0;
      ctrl_q <= CTRL_RST;
      shot_q <= SHOT_RST;
      d1_q   <= DEAD1_RST;
      d2_q   <= DEAD2_RST;
      rc_q   <= RECL_RST;
      ov_q   <= OVR_RST;
    end
    else
    begin
      wp_q   <= wp_d;
      wa_q   <= wa_d;
      rd_q   <= rd_d;
      ctrl_q <= ctrl_d;
      shot_q <= shot_d;
      d1_q   <= d1_d;
      d2_q   <= d2_d;
      rc_q   <= rc_d;
      ov_q   <= ov_d;
    end
  end

  // Common 1 ms tick; a timer may lose up to one tick of its first ms
  always_comb
  begin
    tick_d = (tc_q == 32'(TICK_CYC - 1));
    tc_d   = tick_d ? 32'h0 : tc_q + 32'h1;
  end

  // Lowest index is highest priority
  always_comb
  begin
    hit  = 1'b0;
    pick = 3'h0;
    for (int i = NREQ - 1; i >= 0; i--)
    begin
      if (request[i])
      begin
        hit  = 1'b1;
        pick = 3'(i);
      end
    end
  end

  assign req_cur = request[idx_q];
  assign ovr_any = critical_request || open_fail || close_fail || srst;

  always_comb
  begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    idx_d   = idx_q;
    shot2_d = shot2_q;
    arm_d   = (st_q == ST_LOCK) && (arm_q || lrst);
    if (tick_q && tmr_q != 16'h0)
      tmr_d = tmr_q - 16'h1;
    case (st_q)
      ST_READY:
        // Trip start: no starting or discrimination delay
        if (ctrl_q[CTRL_EN_BIT] && hit)
        begin
          idx_d   = pick;
          shot2_d = !shot_q[0];
          st_d    = (shot_q != 2'h0) ? ST_WOPEN : ST_FINAL;
        end
      ST_WOPEN:
        if (breaker_open && !req_cur)
        begin
          st_d  = ST_DEAD;
          tmr_d = shot2_q ? d2_q : d1_q;
        end
      ST_DEAD:
        if (tmr_q == 16'h0)
          st_d = ST_CLOSE;
      ST_CLOSE:
        if (breaker_closed)
        begin
          st_d  = ST_RECL;
          tmr_d = rc_q;
        end
      ST_RECL:
        if (req_cur)
        begin
          if (!shot2_q && shot_q[1])
          begin
            shot2_d = 1'b1;
            st_d    = ST_WOPEN;
          end
          else
            st_d = ST_FINAL;
        end
        else if (tmr_q == 16'h0)
        begin
          if (ctrl_q[CTRL_OVR_BIT] && ov_q != 16'h0)
          begin
            st_d  = ST_OVR;
            tmr_d = ov_q;
          end
          else
            st_d = ST_READY;
        end
      ST_OVR:
        if (hit)
          st_d = ctrl_q[CTRL_OLOCK_BIT] ? ST_FINAL : ST_READY;
        else if (tmr_q == 16'h0)
          st_d = ST_READY;
      ST_FINAL:
        if (breaker_open)
          st_d = ST_LOCK;
      ST_LOCK:
        // Requests ignored until reset armed and breaker closed
        if (arm_q && breaker_closed)
          st_d = ST_READY;
      default:
        st_d = ST_READY;
    endcase
    if (critical_request && st_q != ST_LOCK)
      st_d = ST_FINAL;
    if (open_fail || close_fail)
      st_d = ST_LOCK;
    if (srst)
    begin
      st_d  = ST_READY;
      tmr_d = 16'h0;
    end
    // Indications follow the next state so they change with it
    act_d   = (st_d == ST_WOPEN) || (st_d == ST_DEAD) ||
              (st_d == ST_CLOSE) || (st_d == ST_RECL);
    s1_d    = act_d && !shot2_d;
    s2_d    = act_d && shot2_d;
    pend_d  = act_d ? NREQ'(5'h01 << idx_d) : '0;
    rcl_d   = (st_d == ST_OVR);
    lock_d  = (st_d == ST_LOCK);
    close_d = (st_d == ST_CLOSE);
    trip_d  = (st_d == ST_FINAL);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tc_q                    <= 32'h0;
      tick_q                  <= 1'b0;
      st_q                    <= ST_READY;
      tmr_q                   <= 16'h0;
      idx_q                   <= 3'h0;
      shot2_q                 <= 1'b0;
      arm_q                   <= 1'b0;
      recloser_active         <= 1'b0;
      first_shot_active       <= 1'b0;
      second_shot_active      <= 1'b0;
      request_pending         <= '0;
      sequence_reclaim_active <= 1'b0;
      sequence_lockout        <= 1'b0;
      close_request           <= 1'b0;
      final_trip              <= 1'b0;
    end
    else
    begin
      tc_q                    <= tc_d;
      tick_q                  <= tick_d;
      st_q                    <= st_d;
      tmr_q                   <= tmr_d;
      idx_q                   <= idx_d;
      shot2_q                 <= shot2_d;
      arm_q                   <= arm_d;
      recloser_active         <= act_d;
      first_shot_active       <= s1_d;
      second_shot_active      <= s2_d;
      request_pending         <= pend_d;
      sequence_reclaim_active <= rcl_d;
      sequence_lockout        <= lock_d;
      close_request           <= close_d;
      final_trip              <= trip_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_start;
    (st_q == ST_READY && hit && ctrl_q[0] && shot_q[0] && !ovr_any) |=>
      recloser_active && first_shot_active && $onehot(request_pending);
  endproperty
  a_start: assert property (p_start) else $error("start flags not raised");

  property p_dead;
    $rose(st_q == ST_DEAD) |-> $past(breaker_open) && !$past(req_cur);
  endproperty
  a_dead: assert property (p_dead) else $error("dead time began early");

  property p_close;
    (st_q == ST_DEAD && tmr_q == 16'h0 && !ovr_any) |=> close_request;
  endproperty
  a_close: assert property (p_close) else $error("no close after dead time");

  property p_drop;
    (close_request && breaker_closed && !ovr_any) |=>
      !close_request && st_q == ST_RECL && tmr_q == rc_q;
  endproperty
  a_drop: assert property (p_drop) else $error("close not withdrawn");

  property p_adv;
    (st_q == ST_RECL && req_cur && !shot2_q && shot_q[1] && !ovr_any) |=>
      second_shot_active && !first_shot_active && st_q == ST_WOPEN;
  endproperty
  a_adv: assert property (p_adv) else $error("no shot advance");

  property p_final;
    (st_q == ST_RECL && req_cur && (shot2_q || !shot_q[1]) && !ovr_any) |=>
      final_trip && !recloser_active && request_pending == '0;
  endproperty
  a_final: assert property (p_final) else $error("no final trip");

  property p_hold;
    (sequence_lockout && !arm_q && !srst) |=> sequence_lockout;
  endproperty
  a_hold: assert property (p_hold) else $error("lockout left early");

  property p_quiet;
    (st_q == ST_RECL && tmr_q == 16'h0 && !req_cur && !ovr_any) |=>
      !recloser_active && request_pending == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("flags kept after reclaim");

  property p_ovr_end;
    (st_q == ST_OVR && tmr_q == 16'h0 && !hit && !ovr_any) |=> st_q == ST_READY;
  endproperty
  a_ovr_end: assert property (p_ovr_end) else $error("not ready after reclaim");

  property p_crit;
    (critical_request && st_q != ST_LOCK && !open_fail && !close_fail && !srst)
      |=> final_trip;
  endproperty
  a_crit: assert property (p_crit) else $error("critical request missed");

  property p_fail;
    ((open_fail || close_fail) && !srst) |=> sequence_lockout;
  endproperty
  a_fail: assert property (p_fail) else $error("failure did not lock");

  property p_srst;
    srst |=> st_q == ST_READY && !recloser_active;
  endproperty
  a_srst: assert property (p_srst) else $error("restart ignored");

  c_two_shot: cover property (second_shot_active ##[1:1000] sequence_lockout);
  c_reclaim:  cover property (sequence_reclaim_active ##1 st_q == ST_READY);
  c_unlock:   cover property (sequence_lockout ##1 !sequence_lockout);
endmodule

/* verif/trs_breaker_model.sv */
// Breaker object model facing the sequencer's close and final trip commands.
// Assumes the bench drives trip, manual close and the close permit on hclk.
`timescale 1ns/1ns
module trs_breaker_model
#(
  parameter int DLY = 4
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic close_request,
  input  wire logic final_trip,
  input  wire logic trip,
  input  wire logic man_close,
  input  wire logic close_ok,
  output logic      breaker_open,
  output logic      breaker_closed,
  output logic      close_fail
);
  logic       pos_q;
  logic [7:0] cnt_q;

  // Status moves only after the coil travel time, never at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_q      <= 1'b1;
      cnt_q      <= 8'h00;
      close_fail <= 1'b0;
    end
    else
    begin
      close_fail <= 1'b0;
      if ((trip || final_trip) && pos_q)
      begin
        cnt_q <= (cnt_q == 8'(DLY)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(DLY))
          pos_q <= 1'b0;
      end
      else if (!pos_q && (man_close || close_request))
      begin
        cnt_q <= (cnt_q == 8'(DLY)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(DLY) && (close_ok || man_close))
          pos_q <= 1'b1;
        if (cnt_q == 8'(DLY) && !close_ok && !man_close)
          close_fail <= 1'b1;
      end
      else
        cnt_q <= 8'h00;
    end
  end

  assign breaker_closed = pos_q;
  assign breaker_open   = !pos_q;
endmodule

/* verif/trip_started_reclose_sequencer_test.sv */
// Self-checking bench for the reclose sequencer with a breaker model.
// Assumes a 1 ms tick shortened to TK cycles and zero-wait bus answers.
`timescale 1ns/1ns
module trip_started_reclose_sequencer_test
  import trs_pkg::*;
;
  localparam int TK = 10;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, close_request, final_trip, recloser_active;
  logic        first_shot_active, second_shot_active, sequence_reclaim_active;
  logic        sequence_lockout, breaker_open, breaker_closed, close_fail;
  logic [31:0] hrdata;
  logic [NREQ-1:0] request = '0;
  logic [NREQ-1:0] request_pending;
  logic        critical_request = 1'b0;
  logic        lockout_reset = 1'b0;
  logic        open_fail = 1'b0;
  logic        trip = 1'b0;
  logic        man_close = 1'b0;
  logic        close_ok = 1'b1;
  logic [13:0] ind;
  int          error_cnt = 0;
  int          checks = 0;

  always #50 hclk = ~hclk;

  trs_sequencer #(.TICK_CYC(TK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .request(request), .critical_request(critical_request), .breaker_open(breaker_open),
    .breaker_closed(breaker_closed), .open_fail(open_fail), .close_fail(close_fail),
    .lockout_reset(lockout_reset), .close_request(close_request), .final_trip(final_trip),
    .recloser_active(recloser_active), .first_shot_active(first_shot_active),
    .second_shot_active(second_shot_active), .request_pending(request_pending),
    .sequence_reclaim_active(sequence_reclaim_active), .sequence_lockout(sequence_lockout));

  trs_breaker_model brk (.hclk(hclk), .hresetn(hresetn), .close_request(close_request),
    .final_trip(final_trip), .trip(trip), .man_close(man_close), .close_ok(close_ok),
    .breaker_open(breaker_open), .breaker_closed(breaker_closed), .close_fail(close_fail));

  // Same bit order as the status word, plus close, trip and breaker levels
  assign ind = {breaker_closed, breaker_open, final_trip, close_request, sequence_lockout,
                sequence_reclaim_active, request_pending, second_shot_active,
                first_shot_active, recloser_active};

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ci(input logic [11:0] e);
    chk("indications", {20'h0, e}, {20'h0, ind[11:0]});
  endtask

  task automatic wait_on(input int i, input logic v, output int n);
    n = 0;
    @(negedge hclk);
    while (ind[i] !== v && n < 3000)
    begin
      @(negedge hclk);
      n++;
    end
    if (n >= 3000)
      chk("wait", 32'h1, 32'h0);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("register", e, r);
  endtask

  task automatic fault(input logic [4:0] rq, input logic [11:0] e);
    @(posedge hclk);
    request <= rq;
    trip    <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    ci(e);
  endtask

  task automatic reopen();
    int n;
    wait_on(12, 1'b1, n);
    @(posedge hclk);
    request <= '0;
    trip    <= 1'b0;
  endtask

  task automatic reclose(input int dead, input logic [11:0] e);
    int n;
    wait_on(10, 1'b1, n);
    chk("dead span", 32'h1, {31'h0, n >= (dead - 1) * TK && n <= dead * TK + 4});
    wait_on(13, 1'b1, n);
    @(negedge hclk);
    ci(e);
  endtask

  task automatic unlock(input logic by_reg, input logic [31:0] ctrl);
    int n;
    if (by_reg)
      wr(CTRL_OFS, ctrl | 32'h2);
    else
    begin
      @(posedge hclk);
      lockout_reset <= 1'b1;
      @(posedge hclk);
      lockout_reset <= 1'b0;
    end
    man_close <= 1'b1;
    wait_on(13, 1'b1, n);
    repeat (2) @(negedge hclk);
    ci(12'h000);
    @(posedge hclk);
    man_close <= 1'b0;
  endtask

  task automatic test_regs();
    logic [31:0] rv [8] = '{32'hd, 32'h3, 32'hc8, 32'hea60, 32'h2710, 32'h2710, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), rv[i]);
    wr(DEAD1_OFS, 32'h3);
    wr(DEAD2_OFS, 32'h5);
    wr(RECL_OFS, 32'd20);
    wr(OVR_OFS, 32'd20);
    rd(DEAD1_OFS, 32'h3);
    $display("test regs done");
  endtask

  task automatic test_both_fail();
    int n;
    fault(5'h02, 12'h013);
    reopen();
    reclose(3, 12'h013);
    fault(5'h02, 12'h015);
    reopen();
    reclose(5, 12'h015);
    fault(5'h02, 12'h800);
    reopen();
    @(negedge hclk);
    ci(12'h200);
    rd(STAT_OFS, 32'h1200);
    fault(5'h02, 12'h200);
    @(posedge hclk);
    request <= '0;
    trip    <= 1'b0;
    man_close <= 1'b1;
    wait_on(13, 1'b1, n);
    repeat (2) @(negedge hclk);
    ci(12'h200);
    unlock(1'b0, 32'h0);
    $display("test both_fail done");
  endtask

  task automatic test_reclaim();
    int n;
    fault(5'h02, 12'h013);
    reopen();
    reclose(3, 12'h013);
    wait_on(8, 1'b1, n);
    ci(12'h100);
    chk("reclaim span", 32'h1, {31'h0, n >= 19 * TK - 2 && n <= 20 * TK + 2});
    wait_on(8, 1'b0, n);
    ci(12'h000);
    chk("overall span", 32'h1, {31'h0, n >= 19 * TK - 2 && n <= 20 * TK + 2});
    fault(5'h02, 12'h013);
    reopen();
    reclose(3, 12'h013);
    wait_on(8, 1'b1, n);
    fault(5'h01, 12'h800);
    reopen();
    @(negedge hclk);
    ci(12'h200);
    unlock(1'b1, 32'hd);
    $display("test reclaim done");
  endtask

  task automatic test_zero();
    int n;
    fault(5'h02, 12'h013);
    reopen();
    wr(CTRL_OFS, 32'h1d);
    @(negedge hclk);
    ci(12'h000);
    @(posedge hclk);
    man_close <= 1'b1;
    wait_on(13, 1'b1, n);
    @(posedge hclk);
    man_close <= 1'b0;
    wr(CTRL_OFS, 32'h9);
    wr(RECL_OFS, 32'h0);
    fault(5'h14, 12'h023);
    reopen();
    reclose(3, 12'h023);
    @(negedge hclk);
    ci(12'h000);
    wr(CTRL_OFS, 32'h5);
    fault(5'h02, 12'h013);
    reopen();
    reclose(3, 12'h013);
    wait_on(8, 1'b1, n);
    chk("zero reclaim span", 32'h1, {31'h0, n <= 1});
    fault(5'h01, 12'h000);
    @(negedge hclk);
    ci(12'h00b);
    reopen();
    reclose(3, 12'h00b);
    wait_on(8, 1'b1, n);
    wait_on(8, 1'b0, n);
    ci(12'h000);
    wr(CTRL_OFS, 32'hd);
    wr(RECL_OFS, 32'd20);
    $display("test zero done");
  endtask

  task automatic test_halt();
    int n;
    wr(SHOT_OFS, 32'h2);
    fault(5'h02, 12'h015);
    @(posedge hclk);
    critical_request <= 1'b1;
    @(posedge hclk);
    critical_request <= 1'b0;
    @(negedge hclk);
    ci(12'h800);
    reopen();
    @(negedge hclk);
    ci(12'h200);
    unlock(1'b0, 32'h0);
    wr(SHOT_OFS, 32'h3);
    fault(5'h02, 12'h013);
    close_ok <= 1'b0;
    reopen();
    wait_on(9, 1'b1, n);
    ci(12'h200);
    close_ok <= 1'b1;
    unlock(1'b1, 32'hd);
    fault(5'h02, 12'h013);
    @(posedge hclk);
    open_fail <= 1'b1;
    @(posedge hclk);
    open_fail <= 1'b0;
    @(negedge hclk);
    ci(12'h200);
    reopen();
    unlock(1'b0, 32'h0);
    $display("test halt done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A whole run needs under two thousand cycles
  initial
  begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_both_fail();
    test_reclaim();
    test_zero();
    test_halt();
    finish_test();
  end
endmodule
